// ==== hw/rcc_pkg.sv ====
// Constants for the reset cause and control register block.
package rcc_pkg;
    localparam int AXI_AW = 32;
    localparam int AXI_DW = 32;
    localparam int REG_W = 16;
    localparam logic [AXI_AW-1:0] RCC_CTRL_OFS = 32'h0000_0000;
    localparam logic [AXI_AW-1:0] RCC_STAT_OFS = 32'h0000_0004;
    localparam logic [AXI_AW-1:0] RCC_MASK_OFS = 32'h0000_0008;
    localparam int B_TRAP = 15;
    localparam int B_IOPU = 14;
    localparam int B_FREG = 11;
    localparam int B_MISMATCH = 9;
    localparam int B_VREG = 8;
    localparam int B_EXT = 7;
    localparam int B_INSTR = 6;
    localparam int B_WDT_EN = 5;
    localparam int B_WDT_TO = 4;
    localparam int B_SLEEP = 3;
    localparam int B_IDLE = 2;
    localparam int B_BROWN = 1;
    localparam int B_POR = 0;
    localparam logic [REG_W-1:0] RCC_IMPL_MASK = 16'hcbff;
    localparam logic [REG_W-1:0] RCC_CTRL_RST = 16'h0003;
    localparam logic [REG_W-1:0] RCC_STAT_RST = 16'h0000;
    localparam logic [REG_W-1:0] RCC_MASK_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RST_SYNC_RST = 2'h0;
endpackage

// ==== hw/rcc_top.sv ====
// Reset cause and control register with AXI4-Lite access and an event interrupt.
//
// Register access over AXI4-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
module rcc_top
(
    // Clock and power-on reset
    input wire logic core_clk,
    input wire logic rstn,
    // AXI4-Lite write address and data
    input wire logic [rcc_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [rcc_pkg::AXI_DW-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [rcc_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [rcc_pkg::AXI_DW-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Reset cause events from the reset controller
    input wire logic trap_conflict_evt,
    input wire logic illegal_op_pointer_evt,
    input wire logic config_mismatch_evt,
    input wire logic master_clear_pin_evt,
    input wire logic reset_instruction_evt,
    input wire logic watchdog_timeout_evt,
    input wire logic brown_out_evt,
    input wire logic sleep_wake_evt,
    input wire logic idle_wake_evt,
    // Configuration fuse
    input wire logic watchdog_fuse_enable,
    // Controls and interrupt
    output logic watchdog_enable,
    output logic regulator_active_in_sleep,
    output logic flash_regulator_active_in_sleep,
    output logic irq
);
    import rcc_pkg::*;

    logic [1:0] rst_pipe_q;
    logic rst_n;
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic [AXI_AW-1:0] awaddr_q, awaddr_d;
    logic [REG_W-1:0] wdata_q, wdata_d;
    logic [1:0] wstrb_q, wstrb_d;
    logic arready_q, arready_d, rvalid_q, rvalid_d;
    logic [AXI_DW-1:0] rdata_q, rdata_d;
    logic [1:0] rresp_q, rresp_d;
    logic [REG_W-1:0] rcc_q, rcc_d, stat_q, stat_d, mask_q, mask_d;
    logic wdt_q, wdt_d, vreg_q, vreg_d, freg_q, freg_d, irq_q, irq_d;
    logic [REG_W-1:0] hw_set, bm;
    logic do_wr, wr_rcc, wr_stat, wr_mask;

    // Power-on reset is released through two flops; only the second is used.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            rst_pipe_q <= RST_SYNC_RST;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end
    assign rst_n = rst_pipe_q[1];

    // Each hardware event maps onto its own flag bit.
    always_comb
    begin
        hw_set = '0;
        hw_set[B_TRAP] = trap_conflict_evt;
        hw_set[B_IOPU] = illegal_op_pointer_evt;
        hw_set[B_MISMATCH] = config_mismatch_evt;
        hw_set[B_EXT] = master_clear_pin_evt;
        hw_set[B_INSTR] = reset_instruction_evt;
        hw_set[B_WDT_TO] = watchdog_timeout_evt;
        hw_set[B_SLEEP] = sleep_wake_evt;
        hw_set[B_IDLE] = idle_wake_evt;
        hw_set[B_BROWN] = brown_out_evt;
    end

    assign do_wr = aw_full_q && w_full_q && !bvalid_q;
    assign wr_rcc = do_wr && (awaddr_q[AXI_AW-1:2] == RCC_CTRL_OFS[AXI_AW-1:2]);
    assign wr_stat = do_wr && (awaddr_q[AXI_AW-1:2] == RCC_STAT_OFS[AXI_AW-1:2]);
    assign wr_mask = do_wr && (awaddr_q[AXI_AW-1:2] == RCC_MASK_OFS[AXI_AW-1:2]);
    assign bm = {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Write channels are taken independently and held until both are present.
    always_comb
    begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (s_axi_awvalid && awready_q)
        begin
            aw_full_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q)
        begin
            w_full_d = 1'b1;
            wdata_d = s_axi_wdata[REG_W-1:0];
            wstrb_d = s_axi_wstrb[1:0];
        end
        if (do_wr)
        begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = (wr_rcc || wr_stat || wr_mask) ? RESP_OKAY : RESP_SLVERR;
        end
        else if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        awready_d = !aw_full_d;
        wready_d = !w_full_d;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= 2'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end
        else
        begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
        end
    end

    // Reads answer one cycle after the address is taken.
    always_comb
    begin
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (s_axi_arvalid && arready_q)
        begin
            rvalid_d = 1'b1;
            rresp_d = RESP_OKAY;
            if (s_axi_araddr[AXI_AW-1:2] == RCC_CTRL_OFS[AXI_AW-1:2])
                rdata_d = {16'h0000, rcc_q};
            else if (s_axi_araddr[AXI_AW-1:2] == RCC_STAT_OFS[AXI_AW-1:2])
                rdata_d = {16'h0000, stat_q};
            else if (s_axi_araddr[AXI_AW-1:2] == RCC_MASK_OFS[AXI_AW-1:2])
                rdata_d = {16'h0000, mask_q};
            else
            begin
                rdata_d = '0;
                rresp_d = RESP_SLVERR;
            end
        end
        else if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end
        else
        begin
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // A hardware set in the same cycle as a software clear wins, so no cause is lost.
    // There is no reset output: software writes only store values.
    always_comb
    begin
        rcc_d = rcc_q;
        stat_d = stat_q;
        mask_d = mask_q;
        if (wr_rcc)
            rcc_d = (rcc_q & ~bm) | (wdata_q & bm);
        if (wr_stat)
            stat_d = stat_q & ~(wdata_q & bm);
        if (wr_mask)
            mask_d = (mask_q & ~bm) | (wdata_q & bm);
        rcc_d = (rcc_d | hw_set) & RCC_IMPL_MASK;
        stat_d = (stat_d | hw_set) & RCC_IMPL_MASK;
        mask_d = mask_d & RCC_IMPL_MASK;
        wdt_d = rcc_q[B_WDT_EN] || watchdog_fuse_enable;
        vreg_d = rcc_q[B_VREG];
        freg_d = rcc_q[B_FREG];
        irq_d = |(stat_q & mask_q);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rcc_q <= RCC_CTRL_RST;
            stat_q <= RCC_STAT_RST;
            mask_q <= RCC_MASK_RST;
            wdt_q <= 1'b0;
            vreg_q <= 1'b0;
            freg_q <= 1'b0;
            irq_q <= 1'b0;
        end
        else
        begin
            rcc_q <= rcc_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            wdt_q <= wdt_d;
            vreg_q <= vreg_d;
            freg_q <= freg_d;
            irq_q <= irq_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
    assign watchdog_enable = wdt_q;
    assign regulator_active_in_sleep = vreg_q;
    assign flash_regulator_active_in_sleep = freg_q;
    assign irq = irq_q;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_pin_set_write;
        wr_rcc && wstrb_q[0] && wdata_q[B_EXT];
    endsequence

    sequence s_flag_idle;
        rcc_q[B_INSTR] && !wr_rcc;
    endsequence

    a_por_value: assert property ($rose(rst_n) |-> rcc_q == RCC_CTRL_RST)
        else $error("flags not at power-on value after reset release");
    a_trap_flag: assert property (trap_conflict_evt |=> rcc_q[B_TRAP])
        else $error("trap event did not set bit 15");
    a_iopu_flag: assert property (illegal_op_pointer_evt |=> rcc_q[B_IOPU])
        else $error("opcode or pointer event did not set bit 14");
    a_ext_flag: assert property (master_clear_pin_evt |=> rcc_q[B_EXT] ##1 rcc_q[B_EXT] || $past(wr_rcc))
        else $error("pin reset flag not set or lost");
    a_sw_set: assert property (s_pin_set_write |=> rcc_q[B_EXT] && bvalid_q)
        else $error("software set of pin flag failed");
    a_swr_flag: assert property (reset_instruction_evt |=> rcc_q[B_INSTR])
        else $error("reset instruction flag not set");
    a_watchdog_timeout_flag_flag: assert property (watchdog_timeout_evt |=> rcc_q[B_WDT_TO])
        else $error("watchdog timeout flag not set");
    a_cm_flag: assert property (config_mismatch_evt |=> rcc_q[B_MISMATCH])
        else $error("mismatch flag not set");
    a_bor_flag: assert property (brown_out_evt |=> rcc_q[B_BROWN])
        else $error("brown-out flag not set");
    a_flag_hold: assert property (s_flag_idle |=> rcc_q[B_INSTR])
        else $error("reset cause flag dropped without a write");
    a_unimpl_zero: assert property ((rcc_q & ~RCC_IMPL_MASK) == 16'h0000)
        else $error("unimplemented bit reads nonzero");
    a_wdt_on: assert property ((rcc_q[B_WDT_EN] || watchdog_fuse_enable) |=> watchdog_enable)
        else $error("watchdog not enabled");
    a_wdt_fuse: assert property (watchdog_fuse_enable [*2] |=> watchdog_enable)
        else $error("fuse did not hold the watchdog enabled");
    a_wdt_off: assert property (!rcc_q[B_WDT_EN] && !watchdog_fuse_enable |=> !watchdog_enable)
        else $error("watchdog enabled while disabled");
    a_vreg_follow: assert property (##1 regulator_active_in_sleep == $past(rcc_q[B_VREG]))
        else $error("regulator control does not follow standby bit");
    a_freg_follow: assert property (##1 flash_regulator_active_in_sleep == $past(rcc_q[B_FREG]))
        else $error("flash regulator control does not follow its standby bit");
endmodule // rcc_top

// ==== test/tb_rcc_top.sv ====
// Self-checking bench for the reset cause and control register block.
`timescale 1ns/100ps
module tb_rcc_top;
    import rcc_pkg::*;
    logic core_clk, rstn, awvalid, wvalid, bready, arvalid, rready, fuse;
    logic awready, wready, bvalid, arready, rvalid, wden, reg_act, freg_act, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, rd, v, exp, bm;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [8:0] evt, e;
    logic [31:0] seed;
    int fails, total_checks;
    // Flag position of each event input, in the order of the evt vector.
    int ebit [9] = '{15, 14, 9, 7, 6, 4, 1, 3, 2};

    rcc_top dut
    (
        .core_clk(core_clk), .rstn(rstn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trap_conflict_evt(evt[0]), .illegal_op_pointer_evt(evt[1]),
        .config_mismatch_evt(evt[2]), .master_clear_pin_evt(evt[3]),
        .reset_instruction_evt(evt[4]), .watchdog_timeout_evt(evt[5]),
        .brown_out_evt(evt[6]), .sleep_wake_evt(evt[7]), .idle_wake_evt(evt[8]),
        .watchdog_fuse_enable(fuse), .watchdog_enable(wden),
        .regulator_active_in_sleep(reg_act), .flash_regulator_active_in_sleep(freg_act),
        .irq(irq)
    );

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] emap(input logic [8:0] ev);
        logic [31:0] m;
        m = 32'h0;
        for (int i = 0; i < 9; i++)
            if (ev[i])
                m[ebit[i]] = 1'b1;
        return m;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want)
        begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic chk_b(input logic got, input logic want);
        chk({31'h0, got}, {31'h0, want});
    endtask

    // Handshakes are judged mid-cycle so the decision never races the design's edge.
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        tb = 1'b0;
        while (!tb)
        begin
            @(negedge core_clk);
            ta = awvalid && awready;
            tw = wvalid && wready;
            tb = bvalid;
            rsp = bresp;
            @(posedge core_clk);
            if (ta)
                awvalid <= 1'b0;
            if (tw)
                wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic rdr(input logic [31:0] a);
        logic ta, tr;
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        tr = 1'b0;
        while (!tr)
        begin
            @(negedge core_clk);
            ta = arvalid && arready;
            tr = rvalid;
            rd = rdata;
            rsp = rresp;
            @(posedge core_clk);
            if (ta)
                arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic end_sim;
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #100000;
        fails++;
        end_sim();
    end

    initial
    begin
        seed = 32'd76915;
        {rstn, awvalid, wvalid, bready, arvalid, rready, fuse} = 7'h0;
        {awaddr, wdata, araddr, evt} = '0;
        wstrb = 4'hf;
        repeat (2) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        rdr(RCC_CTRL_OFS);
        chk(rd, 32'h0000_0003);
        chk({30'h0, rsp}, 32'h0);
        rdr(32'h0000_0010);
        chk({30'h0, rsp}, 32'h2);
        wr(32'h0000_0010, 32'hffff);
        chk({30'h0, rsp}, 32'h2);
        $display("test reset_and_unmapped done");
        wr(RCC_CTRL_OFS, 32'hffff_ffff);
        chk({30'h0, rsp}, 32'h0);
        rdr(RCC_CTRL_OFS);
        chk(rd, 32'h0000_cbff);
        chk_b(wden, 1'b1);
        chk_b(reg_act & freg_act, 1'b1);
        wr(RCC_CTRL_OFS, 32'h0);
        repeat (2) @(negedge core_clk);
        chk_b(wden | reg_act | freg_act, 1'b0);
        @(posedge core_clk);
        fuse <= 1'b1;
        repeat (3) @(negedge core_clk);
        chk_b(wden, 1'b1);
        @(posedge core_clk);
        fuse <= 1'b0;
        $display("test control_bits done");
        // Every event once with the interrupt enabled, then the trap event once with it masked off.
        for (int i = 0; i < 10; i++)
        begin
            wr(RCC_MASK_OFS, (i < 9) ? 32'hcbff : 32'h0);
            rdr(RCC_MASK_OFS);
            chk(rd, (i < 9) ? 32'hcbff : 32'h0);
            wr(RCC_CTRL_OFS, 32'h0);
            exp = emap(9'h1 << (i % 9));
            @(posedge core_clk);
            evt[i % 9] <= 1'b1;
            @(posedge core_clk);
            evt <= 9'h0;
            repeat (3) @(negedge core_clk);
            chk_b(irq, i < 9);
            rdr(RCC_CTRL_OFS);
            chk(rd, exp);
            rdr(RCC_STAT_OFS);
            chk(rd, exp);
            wr(RCC_STAT_OFS, exp);
            rdr(RCC_STAT_OFS);
            chk(rd, 32'h0);
            chk_b(irq, 1'b0);
        end
        $display("test events done");
        // Random writes and byte strobes, with random events landing before the read back.
        // The expected value carries on from the last event test, which left only bit 15 set.
        for (int n = 0; n < 40; n++)
        begin
            v = xs();
            e = v[24:16];
            bm = {16'h0, {8{v[29]}}, {8{v[28]}}};
            wstrb <= v[31:28];
            wr(RCC_CTRL_OFS, v);
            @(posedge core_clk);
            evt <= e;
            @(posedge core_clk);
            evt <= 9'h0;
            rdr(RCC_CTRL_OFS);
            exp = (((exp & ~bm) | (v & bm)) & 32'hcbff) | emap(e);
            chk(rd, exp);
        end
        $display("test random done");
        end_sim();
    end
endmodule // tb_rcc_top
